// >>> src/spvl_defs.svh
`ifndef SPVL_DEFS_SVH
`define SPVL_DEFS_SVH

// ----------------------------------------------------------------
// register word addresses (byte addresses, aligned words)
// ----------------------------------------------------------------
`define SPVL_ADDR_W 8
`define SPVL_OFF_CTRL 8'h00
`define SPVL_OFF_PMR 8'h04
`define SPVL_OFF_RPR 8'h08
`define SPVL_OFF_BPR_S 8'h0c
`define SPVL_OFF_BPR_NS 8'h10
`define SPVL_OFF_HPEND 8'h14
`define SPVL_OFF_STATUS 8'h18
`define SPVL_OFF_PRIO 8'h40
`define SPVL_OFF_SEC 8'h80

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SPVL_CTRL_SBP_BIT 0
`define SPVL_STAT_SIG_BIT 0
`define SPVL_STAT_SEC_BIT 1
`define SPVL_PRIO_TOP 7
`define SPVL_RST_PRIO 8'h00
`define SPVL_RST_PMR 8'h00
`define SPVL_RST_RPR 8'hff
`define SPVL_RST_BPR_S 3'h2
`define SPVL_RST_BPR_NS 3'h3
`define SPVL_IMPL_BITS 8
`define SPVL_NUM_INT 16

`endif

// >>> src/spvl_pkg.sv
package spvl_pkg;
  typedef logic [7:0] spvl_prio_t;
  typedef logic [2:0] spvl_bp_t;
endpackage : spvl_pkg

// >>> src/spvl_view_if.sv
`timescale 1ns/1ps
// stored value plus access security going in, view coming out
interface spvl_view_if;
  import spvl_pkg::*;
  logic ns;
  logic int_secure;
  spvl_prio_t stored;
  spvl_prio_t wdata;
  spvl_prio_t impl_mask;
  spvl_prio_t rview;
  spvl_prio_t next_stored;
  logic wr_ok;
  modport host (output ns, int_secure, stored, wdata, impl_mask,
    input rview, next_stored, wr_ok);
  modport xlat (input ns, int_secure, stored, wdata, impl_mask,
    output rview, next_stored, wr_ok);
endinterface : spvl_view_if

// >>> src/spvl_prio_xlat.sv
`timescale 1ns/1ps
// secure / non-secure translation of one priority field
module spvl_prio_xlat
  import spvl_pkg::*;
(
  spvl_view_if.xlat v
);
  wire ns_of_ns = v.ns && !v.int_secure;
  // stored bits 6:0 moved up, bit 0 low, whatever bit 7 holds
  wire [7:0] ns_read = {v.stored[6:0], 1'b0} & v.impl_mask & 8'hfe;
  // non-secure write shifted down with bit 7 forced high
  wire [7:0] ns_write = {1'b1, v.wdata[7:1]} & v.impl_mask;
  // secure write kept as written in implemented bits
  wire [7:0] s_write = v.wdata & v.impl_mask;

  // secure interrupts are invisible to non-secure accesses
  assign v.wr_ok = !(v.ns && v.int_secure);
  assign v.rview = !v.ns ? v.stored :
    (v.int_secure ? 8'h00 : ns_read);
  assign v.next_stored = ns_of_ns ? ns_write : s_write;
endmodule : spvl_prio_xlat

// >>> src/spvl_core.sv
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "spvl_defs.svh"

// Overview of operation
// - secure write may clear bit7, stored unchanged
// - ns read of bit7-clear value shifts left
// - ns write always stores bit7 set
// - pmr bit7 clear: ns reads zero, ignored
// - rpr bit7 clear: ns reads zero
// - secure interrupt field hidden from ns access
// - ns view values always even
// - ns granularity twice the secure one
// - secure interrupts use secure binary point
// - ns uses ns point unless shared select
// - ns point n groups bits 7 to n
// - grouping uses stored value, not view
// - secure interrupts may get low priorities
// - all-ones write reads back implemented bits
// - ns write shifts right, forces bit7
// - five to eight upper bits implemented
// - secure read returns stored value exactly
// - lower value means higher priority
module spvl_core
  import spvl_pkg::*;
#(
  parameter int NUM_INT = `SPVL_NUM_INT,
  parameter int IMPL_BITS = `SPVL_IMPL_BITS
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`SPVL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_nonsecure,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_INT-1:0] int_pending,
  input wire logic int_active_any,
  output logic signal_secure,
  output logic signal_nonsecure
);

  // ----------------------------------------------------------------
  // implemented bit mask
  // ----------------------------------------------------------------
  localparam int IW = (IMPL_BITS < 5) ? 5 : (IMPL_BITS > 8 ? 8 : IMPL_BITS);
  // only the upper bits exist, lower ones read zero
  localparam spvl_prio_t IMPL_MASK = spvl_prio_t'(8'hff << (8 - IW));
  localparam int IDX_W = (NUM_INT > 1) ? $clog2(NUM_INT) : 1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spvl_prio_t prio [NUM_INT];
  logic [NUM_INT-1:0] sec_int;
  spvl_prio_t pmr;
  spvl_prio_t rpr;
  spvl_bp_t bpr_s;
  spvl_bp_t bpr_ns;
  logic shared_point_select;
  logic ack_phase;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = avs_read || avs_write;
  // one wait cycle keeps read data on a flop
  assign avs_waitrequest = req && !ack_phase;
  wire take = req && ack_phase;
  wire wr_take = take && avs_write;
  wire [`SPVL_ADDR_W-1:0] a = avs_address;
  wire [IDX_W-1:0] pidx = IDX_W'(a[IDX_W+1:2]);
  wire hit_prio = (a >= `SPVL_OFF_PRIO) &&
    (a < `SPVL_OFF_PRIO + 8'(NUM_INT * 4));
  wire hit_ctrl = a == `SPVL_OFF_CTRL;
  wire hit_pmr = a == `SPVL_OFF_PMR;
  wire hit_rpr = a == `SPVL_OFF_RPR;
  wire hit_bs = a == `SPVL_OFF_BPR_S;
  wire hit_bns = a == `SPVL_OFF_BPR_NS;
  wire hit_hp = a == `SPVL_OFF_HPEND;
  wire hit_st = a == `SPVL_OFF_STATUS;
  wire hit_sec = a == `SPVL_OFF_SEC;
  wire ns = avs_nonsecure;

  // ----------------------------------------------------------------
  // priority field translation
  // ----------------------------------------------------------------
  spvl_view_if view ();
  assign view.ns = ns;
  assign view.int_secure = sec_int[pidx];
  assign view.stored = prio[pidx];
  assign view.wdata = avs_writedata[7:0];
  assign view.impl_mask = IMPL_MASK;

  spvl_prio_xlat u_xlat (
    .v(view)
  );

  // ----------------------------------------------------------------
  // mask and running priority views
  // ----------------------------------------------------------------
  wire pmr_hidden = ns && !pmr[`SPVL_PRIO_TOP];
  wire [7:0] pmr_view = pmr_hidden ? 8'h00 :
    (ns ? {pmr[6:0], 1'b0} : pmr);
  wire [7:0] rpr_view = (ns && !rpr[`SPVL_PRIO_TOP]) ? 8'h00 :
    (ns ? {rpr[6:0], 1'b0} : rpr);
  // ns write lands in the top half like a field write
  wire [7:0] pmr_wr = (ns ? {1'b1, avs_writedata[7:1]} :
    avs_writedata[7:0]) & IMPL_MASK;
  // secure-only registers read zero for ns accesses
  wire s_only = !ns;

  // ----------------------------------------------------------------
  // highest pending by stored value, lower number wins
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] best_idx;
  logic best_vld;
  always_comb begin
    best_idx = '0;
    best_vld = 1'b0;
    for (int i = 0; i < NUM_INT; i++) begin
      if (int_pending[i] &&
          (!best_vld || prio[i] < prio[best_idx])) begin
        best_idx = IDX_W'(i);
        best_vld = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // group masks for preemption
  // ----------------------------------------------------------------
  // secure: point n+1 splits; ns: point n splits, one bit more group
  wire [3:0] s_n = {1'b0, bpr_s} + 4'h1;
  wire [7:0] smsk = 8'(8'hff << s_n);
  wire [7:0] nsmsk_own = 8'(8'hff << bpr_ns);
  wire [7:0] nsmsk = shared_point_select ? smsk : nsmsk_own;
  wire [7:0] best_prio = prio[best_idx];
  wire best_sec = sec_int[best_idx];
  wire [7:0] grp_mask = best_sec ? smsk : nsmsk;
  wire pass_pmr = best_vld && (best_prio < pmr);
  // raw stored priority against masked running priority
  wire preempt = !int_active_any || (best_prio < (rpr & grp_mask));
  wire sig = pass_pmr && preempt;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00; // unmapped addresses read zero
    if (hit_prio) rd_mux = view.rview;
    else if (hit_pmr) rd_mux = pmr_view;
    else if (hit_rpr) rd_mux = rpr_view;
    else if (hit_ctrl) rd_mux = s_only ? {7'h0, shared_point_select} : 8'h0;
    else if (hit_bs) rd_mux = s_only ? {5'h0, bpr_s} : {5'h0, bpr_ns};
    else if (hit_bns) rd_mux = s_only ? {5'h0, bpr_ns} : 8'h0;
    else if (hit_hp) rd_mux = 8'(best_idx);
    else if (hit_st) rd_mux = {6'h0, signal_secure | signal_nonsecure, sig};
  end
  wire [31:0] sec_rd = s_only ? 32'(sec_int) : 32'h0;

  // ----------------------------------------------------------------
  // bus handshake and read data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_phase <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_phase <= req && !ack_phase;
      if (avs_read && !ack_phase)
        avs_readdata <= hit_sec ? sec_rd : {24'h0, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // priority fields, one flop group per interrupt
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_INT; g++) begin : g_prio
      wire we = wr_take && hit_prio && (pidx == IDX_W'(g)) && view.wr_ok;
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) prio[g] <= `SPVL_RST_PRIO;
        else if (we) prio[g] <= view.next_stored;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // cpu interface registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pmr <= `SPVL_RST_PMR;
      bpr_s <= `SPVL_RST_BPR_S;
      bpr_ns <= `SPVL_RST_BPR_NS;
      shared_point_select <= 1'b0;
      sec_int <= '0;
    end else if (wr_take) begin
      if (hit_pmr && !pmr_hidden) pmr <= pmr_wr;
      if (hit_bs && !ns) bpr_s <= avs_writedata[2:0];
      if ((hit_bs && ns) || (hit_bns && !ns)) bpr_ns <= avs_writedata[2:0];
      if (hit_ctrl && !ns)
        shared_point_select <= avs_writedata[`SPVL_CTRL_SBP_BIT];
      if (hit_sec && !ns) sec_int <= avs_writedata[NUM_INT-1:0];
    end
  end

  // running priority tracks the group of what was signalled
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rpr <= `SPVL_RST_RPR;
      signal_secure <= 1'b0;
      signal_nonsecure <= 1'b0;
    end else begin
      signal_secure <= sig && best_sec;
      signal_nonsecure <= sig && !best_sec;
      if (!int_active_any) rpr <= `SPVL_RST_RPR;
      else if (sig) rpr <= best_prio & grp_mask;
    end
  end

endmodule : spvl_core

// >>> tb/spvl_core_chk.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module spvl_core_chk #(
  parameter int NUM_INT = 16,
  parameter int IMPL_BITS = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_nonsecure,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NUM_INT-1:0] int_pending,
  input wire logic signal_secure,
  input wire logic signal_nonsecure
);
  // low bits that must read zero in each view
  localparam logic [7:0] SLOW = 8'hff >> IMPL_BITS;
  localparam logic [7:0] NSLOW = {SLOW[6:0], 1'b1};
  wire logic req = avs_read || avs_write;
  wire logic fld = avs_read && !avs_waitrequest && avs_address[7:6] == 2'b01;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_first;
    req && avs_waitrequest;
  endsequence
  property p_wait1;
    $rose(req) |-> s_first;
  endproperty
  a_wait1: assert property (p_wait1) else $error("no wait cycle");
  property p_answer;
    s_first |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_excl;
    !(signal_secure && signal_nonsecure);
  endproperty
  a_excl: assert property (p_excl) else $error("both signals high");
  // a pipeline of up to two stages must have drained by then
  property p_idle;
    !(|int_pending) [*3] |-> !signal_secure && !signal_nonsecure;
  endproperty
  a_idle: assert property (p_idle) else $error("signal, none pending");
  property p_sview;
    fld && !avs_nonsecure |-> (avs_readdata[7:0] & SLOW) == 8'h00;
  endproperty
  a_sview: assert property (p_sview) else $error("secure low bits");
  property p_nsview;
    fld && avs_nonsecure |-> (avs_readdata[7:0] & NSLOW) == 8'h00;
  endproperty
  a_nsview: assert property (p_nsview) else $error("ns low bits");
  property p_upper;
    fld |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("field upper bits");
  property p_stand;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_stand: assert property (p_stand) else $error("readdata moved");
endmodule : spvl_core_chk

bind spvl_core spvl_core_chk #(.NUM_INT(NUM_INT),
  .IMPL_BITS(IMPL_BITS)) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_nonsecure(avs_nonsecure),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .int_pending(int_pending), .signal_secure(signal_secure),
  .signal_nonsecure(signal_nonsecure));

// >>> tb/spvl_master.sv
`timescale 1ns/1ps
// ----
// processor bus master
// ----
module spvl_master (
  input wire logic sys_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic avs_nonsecure
);
  // idle at time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_nonsecure = 1'b0;
  end
  // released lines flip so stale values never look valid
  task automatic xfer(input logic wr, input logic ns, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_nonsecure <= ns;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~wd;
  endtask : xfer
endmodule : spvl_master

// >>> tb/spvl_core_tb_top.sv
`timescale 1ns/1ps
// ----
// bench top
// ----
module spvl_core_tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic avs_nonsecure;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] int_pending = 16'h0000;
  logic int_active_any = 1'b0;
  logic signal_secure;
  logic signal_nonsecure;
  logic [31:0] rd;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  // clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      test_done();
    end
  end
  spvl_master i_host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_nonsecure(avs_nonsecure));
  // six implemented bits so both views have masked low bits
  spvl_core #(.NUM_INT(16), .IMPL_BITS(6)) i_dut (.sys_clk(sys_clk),
    .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_nonsecure(avs_nonsecure), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .int_pending(int_pending),
    .int_active_any(int_active_any), .signal_secure(signal_secure),
    .signal_nonsecure(signal_nonsecure));
  // helpers
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task chk_sig(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t signals %b expected %b", $time, got, exp);
    end
  endtask : chk_sig
  task wr(input logic ns, input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, ns, a, d, rd);
  endtask : wr
  task rchk(input logic ns, input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, ns, a, 32'h00000000, rd);
    chk_word(rd, e);
  endtask : rchk
  // bounded wait, signal outputs are registered
  task settle(input logic [1:0] e);
    for (int i = 0; i < 8; i++) begin
      if ({signal_secure, signal_nonsecure} !== e) @(posedge sys_clk);
    end
    chk_sig({signal_secure, signal_nonsecure}, e);
  endtask : settle
  // a pulse lasts one cycle, so look at every edge
  task quiet();
    repeat (4) begin
      @(posedge sys_clk);
      chk_sig({signal_secure, signal_nonsecure}, 2'b00);
    end
  endtask : quiet
  // ----
  // scenarios
  // ----
  task t_reset();
    rchk(1'b0, 8'h04, 32'h00000000);
    rchk(1'b0, 8'h08, 32'h000000ff);
    rchk(1'b0, 8'h0c, 32'h00000002);
    rchk(1'b1, 8'h0c, 32'h00000003);
    rchk(1'b0, 8'h10, 32'h00000003);
    wr(1'b0, 8'h20, 32'hffffffff);
    rchk(1'b0, 8'h20, 32'h00000000);
    wr(1'b0, 8'h00, 32'h00000001);
    rchk(1'b0, 8'h00, 32'h00000001);
    $display("t_reset done");
  endtask : t_reset
  task t_fields();
    wr(1'b1, 8'h40, 32'h0000005a);
    rchk(1'b0, 8'h40, 32'h000000ac);
    rchk(1'b1, 8'h40, 32'h00000058);
    wr(1'b0, 8'h44, 32'h00000034);
    rchk(1'b0, 8'h44, 32'h00000034);
    rchk(1'b1, 8'h44, 32'h00000068);
    wr(1'b1, 8'h44, 32'h00000010);
    rchk(1'b0, 8'h44, 32'h00000088);
    wr(1'b0, 8'h48, 32'h000000ff);
    rchk(1'b0, 8'h48, 32'h000000fc);
    wr(1'b1, 8'h4c, 32'h000000ff);
    rchk(1'b1, 8'h4c, 32'h000000f8);
    $display("t_fields done");
  endtask : t_fields
  task t_secure();
    wr(1'b0, 8'h80, 32'h00000010);
    wr(1'b1, 8'h80, 32'h00000000);
    rchk(1'b0, 8'h80, 32'h00000010);
    wr(1'b0, 8'h50, 32'h000000c0);
    rchk(1'b1, 8'h50, 32'h00000000);
    wr(1'b1, 8'h50, 32'h00000000);
    rchk(1'b0, 8'h50, 32'h000000c0);
    wr(1'b0, 8'h04, 32'h00000040);
    rchk(1'b1, 8'h04, 32'h00000000);
    wr(1'b1, 8'h04, 32'h000000f0);
    rchk(1'b0, 8'h04, 32'h00000040);
    wr(1'b0, 8'h04, 32'h000000f0);
    int_pending <= 16'h0010;
    settle(2'b10);
    int_pending <= 16'h0012;
    settle(2'b01);
    wr(1'b0, 8'h04, 32'h00000080);
    settle(2'b00);
    int_pending <= 16'h0000;
    $display("t_secure done");
  endtask : t_secure
  // running priority ff, then masked priority of each signalled one
  task t_preempt();
    wr(1'b0, 8'h04, 32'h000000ff);
    wr(1'b0, 8'h4c, 32'h000000f8);
    wr(1'b1, 8'h0c, 32'h00000002);
    int_active_any <= 1'b1;
    int_pending <= 16'h0008;
    quiet();
    wr(1'b0, 8'h00, 32'h00000000);
    settle(2'b01);
    wr(1'b0, 8'h0c, 32'h00000007);
    int_pending <= 16'h0018;
    quiet();
    wr(1'b0, 8'h0c, 32'h00000002);
    settle(2'b10);
    wr(1'b0, 8'h50, 32'h00000040);
    rchk(1'b1, 8'h08, 32'h00000000);
    rchk(1'b0, 8'h08, 32'h00000040);
    int_pending <= 16'h0000;
    int_active_any <= 1'b0;
    $display("t_preempt done");
  endtask : t_preempt
  task test_done();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_secure();
    t_preempt();
    test_done();
  end
endmodule : spvl_core_tb_top
